// ### hdl/can_stat_pkg.sv
package can_stat_pkg;

  // Register byte offsets and word indices; each register takes one aligned 32-bit word
  localparam logic [7:0] TX_STATUS_OFS     = 8'h08;
  localparam logic [7:0] TX_PRIORITY_OFS   = 8'h0C;
  localparam logic [7:0] RX_QUEUE_CTRL_OFS = 8'h10;
  localparam logic [7:0] IRQ_ENABLE_OFS    = 8'h14;
  localparam logic [7:0] DIAGNOSTIC_OFS    = 8'h18;
  localparam logic [7:0] PAGE_SELECT_OFS   = 8'h1C;
  localparam logic [7:0] ERROR_STATUS_OFS  = 8'h20;
  localparam logic [7:0] TX_STATUS_IDX     = 8'h02;
  localparam logic [7:0] TX_PRIORITY_IDX   = 8'h03;
  localparam logic [7:0] RX_QUEUE_IDX      = 8'h04;
  localparam logic [7:0] IRQ_ENABLE_IDX    = 8'h05;
  localparam logic [7:0] DIAGNOSTIC_IDX    = 8'h06;
  localparam logic [7:0] PAGE_SELECT_IDX   = 8'h07;

  // Field positions
  localparam int TXOK_LSB     = 4;
  localparam int LOW_LSB      = 5;
  localparam int EMPTY_LSB    = 2;
  localparam int RELEASE_BIT  = 5;
  localparam int OVERRUN_BIT  = 4;
  localparam int FULL_BIT     = 3;
  localparam int WAKE_EN_BIT  = 7;
  localparam int OVR_EN_BIT   = 3;
  localparam int FULL_EN_BIT  = 2;
  localparam int PEND_EN_BIT  = 1;
  localparam int TXE_EN_BIT   = 0;
  localparam int MB2_EN_BIT   = 4;
  localparam int RX_LIVE_BIT  = 3;
  localparam int SAMPLE_BIT   = 2;
  localparam int SILENT_BIT   = 1;
  localparam int LOOP_BIT     = 0;
  localparam int ERR_CODE_LSB = 4;
  localparam int BUS_OFF_BIT  = 2;
  localparam int EPV_BIT      = 1;
  localparam int EWG_BIT      = 0;

  // Writable masks (reserved bits ignored)
  localparam logic [7:0] IER_MASK  = 8'h8F;
  localparam logic [7:0] DIAG_MASK = 8'h13;
  localparam logic [7:0] PAGE_MASK = 8'h07;

  // Reset values
  localparam logic [7:0] IER_RESET   = 8'h00;
  localparam logic [7:0] DIAG_RESET  = 8'h00;
  localparam logic [7:0] PAGE_RESET  = 8'h00;

  // Queue and error limits
  localparam logic [1:0] QUEUE_DEPTH   = 2'h3;
  localparam logic [8:0] WARN_LIMIT    = 9'h060;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
  localparam logic [8:0] BUSOFF_LIMIT  = 9'h0FF;
  localparam logic [2:0] CODE_NONE     = 3'h0;
  localparam logic [2:0] CODE_SW       = 3'h7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0] req_new;
    logic [2:0] done_ok;
    logic [2:0] done_any;
    logic [2:0] pending;
    logic [5:0] rank;
  } tx_events_t;

  typedef struct packed {
    logic       store;
    logic       arrive;
    logic       ok_frame;
    logic       err_valid;
    logic [2:0] err_code;
  } rx_events_t;

endpackage : can_stat_pkg

// ### hdl/can_status_fifo_diag_regs.sv
// How it works
// [RL1] Successful mailbox transmission sets that mailbox's success flag.
// [RL2] Success flag clears on new request or software clear of request-done.
// [RL3] Request-done sets when transmit or abort finishes; software writes one to clear.
// [RL4] Lowest-priority flags only with two or more pending; the lowest-ranked one.
// [RL5] Empty flag reads one while no request pends for that mailbox.
// [RL6] Third-mailbox enable zero: two mailboxes, its empty flag and code MSB zero.
// [RL7] Code field gives next free mailbox, else lowest-priority mailbox.
// [RL8] Release bit frees output slot; ignored when empty; cleared when done.
// [RL9] Overrun flag sets on accepted message while full; write one clears.
// [RL10] Full flag sets at three held; clears on write one or release.
// [RL11] Pending count rises on store, falls on completed release.
// [RL12] Wake, overrun, full, request-done flags interrupt when enabled.
// [RL13] Pending interrupt only on count moving from zero to one.
// [RL14] Diagnostic shows live receive pin and last sample value.
// [RL15] Silent and loopback select bits, independent, zero means normal.
// [RL16] Three-bit page selector picks mailbox, filter, config or queue page.
// [RL17] Last-error code holds latest bus error type, codes one to six.
// [RL18] Error-free transfer clears code; software may write seven.
// [RL19] Bus-off flag when transmit error count exceeds 255.
// [RL20] Error-passive flag when either count exceeds 127.
// [RL21] Error-warning flag when either count exceeds 96.
// [RL22] Wake flag interrupts only when wake enable is set.
// [RL23] Reserved bits read zero, writes to them ignored.
module can_status_fifo_diag_regs (
  input  wire logic                     MCLK,
  input  wire logic                     RST_N,
  input  wire logic [7:0]               AWADDR,
  input  wire logic                     AWVALID,
  output logic                          AWREADY,
  input  wire logic [31:0]              WDATA,
  input  wire logic [3:0]               WSTRB,
  input  wire logic                     WVALID,
  output logic                          WREADY,
  output logic [1:0]                    BRESP,
  output logic                          BVALID,
  input  wire logic                     BREADY,
  input  wire logic [7:0]               ARADDR,
  input  wire logic                     ARVALID,
  output logic                          ARREADY,
  output logic [31:0]                   RDATA,
  output logic [1:0]                    RRESP,
  output logic                          RVALID,
  input  wire logic                     RREADY,
  input  wire can_stat_pkg::tx_events_t TX_EV,
  input  wire can_stat_pkg::rx_events_t RX_EV,
  input  wire logic                     WAKE_EVENT,
  input  wire logic [7:0]               TX_ERR_COUNT,
  input  wire logic [7:0]               RX_ERR_COUNT,
  input  wire logic                     TX_ERR_OVERFLOW,
  input  wire logic                     RX_PIN,
  input  wire logic                     SAMPLE_BIT_IN,
  output logic                          RELEASE_DONE,
  output logic                          THIRD_MB_EN,
  output logic                          SILENT_MODE,
  output logic                          LOOPBACK_MODE,
  output logic [2:0]                    PAGE_SEL,
  output logic                          IRQ_STATUS,
  output logic                          IRQ_TX,
  output logic                          IRQ_RX
);

  logic [2:0] tx_ok_r;
  logic [2:0] req_done_r;
  logic       release_r;
  logic       overrun_r;
  logic       full_r;
  logic [1:0] pending_count_r;
  logic [7:0] irq_en_r;
  logic [7:0] diag_r;
  logic [2:0] page_sel_r;
  logic [2:0] err_code_r;
  logic       wake_flag_r;
  logic       pend_irq_r;

  logic       aw_held_r;
  logic       w_held_r;
  logic [7:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic       w_lane_r;
  logic       rvalid_r;
  logic       bvalid_r;

  logic       wr_fire;
  logic [7:0] wr_byte;
  logic [2:0] mb_mask;
  logic [2:0] pend_eff;
  logic [2:0] empty_mb;
  logic [2:0] lowest;
  logic [1:0] code;
  logic       release_fire;
  logic [1:0] count_nxt;
  logic [7:0] tpr_val;

  function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    wr_hit = (addr == ofs);
  endfunction : wr_hit

  // Error status sits one word above the page select register
  function automatic logic mapped(input logic [7:0] addr);
    mapped = wr_hit(addr, can_stat_pkg::TX_STATUS_OFS) || wr_hit(addr, can_stat_pkg::TX_PRIORITY_OFS)
          || wr_hit(addr, can_stat_pkg::RX_QUEUE_CTRL_OFS) || wr_hit(addr, can_stat_pkg::IRQ_ENABLE_OFS)
          || wr_hit(addr, can_stat_pkg::DIAGNOSTIC_OFS) || wr_hit(addr, can_stat_pkg::PAGE_SELECT_OFS)
          || wr_hit(addr, can_stat_pkg::ERROR_STATUS_OFS);
  endfunction : mapped

  // AXI4-Lite write: address and data taken independently, response after both
  assign AWREADY = !aw_held_r && !bvalid_r;
  assign WREADY  = !w_held_r && !bvalid_r;
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
  assign wr_byte = w_lane_r ? w_data_r : 8'h00;
  assign BVALID  = bvalid_r;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 8'h00;
      w_lane_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      BRESP     <= can_stat_pkg::RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held_r <= 1'b1;
        w_data_r <= WDATA[7:0];
        w_lane_r <= WSTRB[0];
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        BRESP     <= mapped(aw_addr_r) ? can_stat_pkg::RESP_OKAY : can_stat_pkg::RESP_SLVERR;
      end else if (bvalid_r && BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  function automatic logic wr_to(input logic [7:0] ofs);
    wr_to = wr_fire && (aw_addr_r == ofs);
  endfunction : wr_to

  // Mailbox availability
  assign THIRD_MB_EN = diag_r[can_stat_pkg::MB2_EN_BIT];
  assign mb_mask     = {THIRD_MB_EN, 2'b11};
  assign pend_eff    = TX_EV.pending & mb_mask;
  assign empty_mb    = ~TX_EV.pending & mb_mask; // RL5 RL6

  // Lowest-priority flags need at least two pending mailboxes
  always_comb begin
    lowest = 3'b000;
    if ($countones(pend_eff) > 1) begin // RL4
      for (int i = 0; i < 3; i++) begin
        if (pend_eff[i] && TX_EV.rank[2*i +: 2] == 2'd2 - {1'b0, !THIRD_MB_EN}) begin
          lowest[i] = 1'b1;
        end
      end
    end
  end

  // Next free mailbox, else the lowest-priority one
  always_comb begin
    code = 2'd0;
    if (empty_mb[0]) begin // RL7
      code = 2'd0;
    end else if (empty_mb[1]) begin
      code = 2'd1;
    end else if (empty_mb[2]) begin
      code = 2'd2;
    end else if (lowest[1]) begin
      code = 2'd1;
    end else if (lowest[2]) begin
      code = 2'd2;
    end
    if (!THIRD_MB_EN) begin
      code[1] = 1'b0; // RL6
    end
  end

  assign tpr_val = {lowest, empty_mb, code};

  // Transmit success and request-done flags; hardware set wins over clear
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      req_done_r <= 3'b000;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (TX_EV.done_any[i]) begin
          req_done_r[i] <= 1'b1; // RL3
        end else if (wr_to(can_stat_pkg::TX_STATUS_OFS) && wr_byte[i]) begin
          req_done_r[i] <= 1'b0; // RL3
        end
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      tx_ok_r <= 3'b000;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (TX_EV.done_ok[i]) begin
          tx_ok_r[i] <= 1'b1; // RL1
        end else if (TX_EV.req_new[i] || (wr_to(can_stat_pkg::TX_STATUS_OFS) && wr_byte[i])) begin
          tx_ok_r[i] <= 1'b0; // RL2
        end
      end
    end
  end

  // Receive queue: release completes one cycle after software sets the bit
  assign release_fire = release_r;
  assign RELEASE_DONE = release_r;
  assign count_nxt    = pending_count_r + (RX_EV.store ? 2'd1 : 2'd0) - (release_fire ? 2'd1 : 2'd0);

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      release_r <= 1'b0;
    end else if (release_r) begin
      release_r <= 1'b0; // RL8
    end else if (wr_to(can_stat_pkg::RX_QUEUE_CTRL_OFS) && wr_byte[can_stat_pkg::RELEASE_BIT]
                 && pending_count_r != 2'd0) begin
      release_r <= 1'b1; // RL8
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      pending_count_r <= 2'd0;
    end else begin
      pending_count_r <= count_nxt; // RL11
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      overrun_r <= 1'b0;
    end else if (RX_EV.arrive && pending_count_r == can_stat_pkg::QUEUE_DEPTH) begin
      overrun_r <= 1'b1; // RL9
    end else if (wr_to(can_stat_pkg::RX_QUEUE_CTRL_OFS) && wr_byte[can_stat_pkg::OVERRUN_BIT]) begin
      overrun_r <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      full_r <= 1'b0;
    end else if (RX_EV.store && count_nxt == can_stat_pkg::QUEUE_DEPTH) begin
      full_r <= 1'b1; // RL10
    end else if (release_fire || (wr_to(can_stat_pkg::RX_QUEUE_CTRL_OFS) && wr_byte[can_stat_pkg::FULL_BIT])) begin
      full_r <= 1'b0; // RL10
    end
  end

  // Only the empty-to-one step raises the pending interrupt
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      pend_irq_r <= 1'b0;
    end else if (pending_count_r == 2'd0 && count_nxt == 2'd1) begin
      pend_irq_r <= 1'b1; // RL13
    end else if (pending_count_r == 2'd0 || release_fire) begin
      pend_irq_r <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      irq_en_r <= can_stat_pkg::IER_RESET;
    end else if (wr_to(can_stat_pkg::IRQ_ENABLE_OFS)) begin
      irq_en_r <= wr_byte & can_stat_pkg::IER_MASK; // RL23
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      diag_r <= can_stat_pkg::DIAG_RESET;
    end else if (wr_to(can_stat_pkg::DIAGNOSTIC_OFS)) begin
      diag_r <= wr_byte & can_stat_pkg::DIAG_MASK; // RL15 RL23
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      page_sel_r <= can_stat_pkg::PAGE_RESET[2:0];
    end else if (wr_to(can_stat_pkg::PAGE_SELECT_OFS)) begin
      page_sel_r <= wr_byte[2:0]; // RL16
    end
  end

  assign SILENT_MODE   = diag_r[can_stat_pkg::SILENT_BIT];
  assign LOOPBACK_MODE = diag_r[can_stat_pkg::LOOP_BIT];
  assign PAGE_SEL      = page_sel_r;

  // Last error code: a software write of seven stays until hardware updates it
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      err_code_r <= can_stat_pkg::CODE_NONE;
    end else if (RX_EV.err_valid && RX_EV.err_code != can_stat_pkg::CODE_NONE
                 && RX_EV.err_code != can_stat_pkg::CODE_SW) begin
      err_code_r <= RX_EV.err_code; // RL17
    end else if (RX_EV.ok_frame) begin
      err_code_r <= can_stat_pkg::CODE_NONE; // RL18
    end else if (wr_to(can_stat_pkg::ERROR_STATUS_OFS)) begin
      err_code_r <= wr_byte[6:4]; // RL18
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      wake_flag_r <= 1'b0;
    end else if (WAKE_EVENT) begin
      wake_flag_r <= 1'b1;
    end else if (wr_to(can_stat_pkg::ERROR_STATUS_OFS) && wr_byte[7]) begin
      wake_flag_r <= 1'b0;
    end
  end

  logic bus_off;
  logic err_passive;
  logic err_warning;
  assign bus_off     = TX_ERR_OVERFLOW || ({1'b0, TX_ERR_COUNT} > can_stat_pkg::BUSOFF_LIMIT); // RL19
  assign err_passive = ({1'b0, TX_ERR_COUNT} > can_stat_pkg::PASSIVE_LIMIT)
                    || ({1'b0, RX_ERR_COUNT} > can_stat_pkg::PASSIVE_LIMIT); // RL20
  assign err_warning = ({1'b0, TX_ERR_COUNT} > can_stat_pkg::WARN_LIMIT)
                    || ({1'b0, RX_ERR_COUNT} > can_stat_pkg::WARN_LIMIT); // RL21

  // Interrupt lines are level: they stand while flag and enable are both set
  assign IRQ_STATUS = wake_flag_r && irq_en_r[can_stat_pkg::WAKE_EN_BIT]; // RL22
  assign IRQ_TX     = (|req_done_r) && irq_en_r[can_stat_pkg::TXE_EN_BIT]; // RL12
  assign IRQ_RX     = (overrun_r && irq_en_r[can_stat_pkg::OVR_EN_BIT])
                   || (full_r && irq_en_r[can_stat_pkg::FULL_EN_BIT])
                   || (pend_irq_r && irq_en_r[can_stat_pkg::PEND_EN_BIT]); // RL12 RL13

  // Read channel
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (ARADDR)
      can_stat_pkg::TX_STATUS_OFS:     rd_byte = {1'b0, tx_ok_r, 1'b0, req_done_r}; // RL23
      can_stat_pkg::TX_PRIORITY_OFS:   rd_byte = tpr_val;
      can_stat_pkg::RX_QUEUE_CTRL_OFS: rd_byte = {2'b00, release_r, overrun_r, full_r, 1'b0, pending_count_r};
      can_stat_pkg::IRQ_ENABLE_OFS:    rd_byte = irq_en_r;
      can_stat_pkg::DIAGNOSTIC_OFS:    rd_byte = {diag_r[7:4], RX_PIN, SAMPLE_BIT_IN, diag_r[1:0]}; // RL14
      can_stat_pkg::PAGE_SELECT_OFS:   rd_byte = {5'b00000, page_sel_r};
      can_stat_pkg::ERROR_STATUS_OFS:  rd_byte = {wake_flag_r, err_code_r, 1'b0, bus_off, err_passive, err_warning};
      default:                         rd_byte = 8'h00;
    endcase
  end

  assign ARREADY = !rvalid_r;
  assign RVALID  = rvalid_r;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      rvalid_r <= 1'b0;
      RDATA    <= 32'h00000000;
      RRESP    <= can_stat_pkg::RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      rvalid_r <= 1'b1;
      RDATA    <= {24'h000000, rd_byte};
      RRESP    <= mapped(ARADDR) ? can_stat_pkg::RESP_OKAY : can_stat_pkg::RESP_SLVERR;
    end else if (rvalid_r && RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  a_done_sets: assert property (@(posedge MCLK) disable iff (!RST_N)
    TX_EV.done_any[0] |=> req_done_r[0]) else $error("request-done not set"); // RL3
  a_ok_clears: assert property (@(posedge MCLK) disable iff (!RST_N)
    (TX_EV.req_new[2] && !TX_EV.done_ok[2]) |=> !tx_ok_r[2]) else $error("success not cleared"); // RL2
  a_low_single: assert property (@(posedge MCLK) disable iff (!RST_N)
    ($countones(pend_eff) < 2) |-> (lowest == 3'b000)) else $error("lowest with one pending"); // RL4
  a_compat_code: assert property (@(posedge MCLK) disable iff (!RST_N)
    !THIRD_MB_EN |-> (!code[1] && !empty_mb[2])) else $error("third mailbox visible"); // RL6
  a_release_ends: assert property (@(posedge MCLK) disable iff (!RST_N)
    release_r |=> !release_r && pending_count_r == $past(count_nxt)) else $error("release stuck"); // RL8
  a_overrun_set: assert property (@(posedge MCLK) disable iff (!RST_N)
    (RX_EV.arrive && pending_count_r == 2'd3) |=> overrun_r) else $error("overrun missed"); // RL9
  a_warn_level: assert property (@(posedge MCLK) disable iff (!RST_N)
    (TX_ERR_COUNT == 8'd97) |-> err_warning) else $error("warning missed"); // RL21
  a_passive_level: assert property (@(posedge MCLK) disable iff (!RST_N)
    (RX_ERR_COUNT == 8'd127 && TX_ERR_COUNT < 8'd128) |-> !err_passive) else $error("passive early"); // RL20
  a_code_cleared: assert property (@(posedge MCLK) disable iff (!RST_N)
    (RX_EV.ok_frame && !RX_EV.err_valid) |=> err_code_r == 3'h0) else $error("code not cleared"); // RL18

endmodule : can_status_fifo_diag_regs

// ### testbench/can_far_model.sv
module can_far_model (
  input  wire logic                 MCLK,
  output can_stat_pkg::tx_events_t  TX_EV,
  output can_stat_pkg::rx_events_t  RX_EV,
  output logic                      WAKE_EVENT,
  output logic [7:0]                TX_ERR_COUNT,
  output logic [7:0]                RX_ERR_COUNT,
  output logic                      TX_ERR_OVERFLOW,
  output logic                      RX_PIN,
  output logic                      SAMPLE_BIT_IN
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    {TX_EV, RX_EV, WAKE_EVENT, TX_ERR_COUNT, RX_ERR_COUNT, TX_ERR_OVERFLOW, SAMPLE_BIT_IN} = '0;
    // Bus idles recessive
    RX_PIN = 1'b1;
  end

  // Pulses last one cycle; pending, rank and error code stay as levels
  task automatic ev(input logic [17:0] t, input logic [6:0] r, input logic w);
    @(posedge MCLK);
    TX_EV      <= t;
    RX_EV      <= r;
    WAKE_EVENT <= w;
    @(posedge MCLK);
    TX_EV      <= {9'h000, t[8:0]};
    RX_EV      <= {4'h0, r[2:0]};
    WAKE_EVENT <= 1'b0;
  endtask : ev

  task automatic lv(input logic [7:0] tc, input logic [7:0] rc, input logic ov, input logic pin,
                    input logic smp);
    @(posedge MCLK);
    TX_ERR_COUNT    <= tc;
    RX_ERR_COUNT    <= rc;
    TX_ERR_OVERFLOW <= ov;
    RX_PIN          <= pin;
    SAMPLE_BIT_IN   <= smp;
  endtask : lv
endmodule : can_far_model

// ### testbench/can_status_fifo_diag_regs_bench.sv
module can_status_fifo_diag_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic                     MCLK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic [7:0]               AWADDR, ARADDR;
  logic [31:0]              WDATA;
  logic [3:0]               WSTRB;
  wire logic                AWREADY, WREADY, BVALID, ARREADY, RVALID, RELEASE_DONE;
  wire logic                THIRD_MB_EN, SILENT_MODE, LOOPBACK_MODE, IRQ_STATUS, IRQ_TX, IRQ_RX;
  wire logic [1:0]          BRESP, RRESP;
  wire logic [31:0]         RDATA;
  wire logic [2:0]          PAGE_SEL;
  wire logic [7:0]          TX_ERR_COUNT, RX_ERR_COUNT;
  wire logic                WAKE_EVENT, TX_ERR_OVERFLOW, RX_PIN, SAMPLE_BIT_IN;
  can_stat_pkg::tx_events_t TX_EV;
  can_stat_pkg::rx_events_t RX_EV;
  int                       fail_count, cmp_count, cyc, rel_seen;
  logic [1:0]               rs;

  can_status_fifo_diag_regs can_status_fifo_diag_regs_i (.MCLK(MCLK), .RST_N(RST_N), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .TX_EV(TX_EV), .RX_EV(RX_EV),
    .WAKE_EVENT(WAKE_EVENT), .TX_ERR_COUNT(TX_ERR_COUNT), .RX_ERR_COUNT(RX_ERR_COUNT),
    .TX_ERR_OVERFLOW(TX_ERR_OVERFLOW), .RX_PIN(RX_PIN), .SAMPLE_BIT_IN(SAMPLE_BIT_IN),
    .RELEASE_DONE(RELEASE_DONE), .THIRD_MB_EN(THIRD_MB_EN), .SILENT_MODE(SILENT_MODE),
    .LOOPBACK_MODE(LOOPBACK_MODE), .PAGE_SEL(PAGE_SEL), .IRQ_STATUS(IRQ_STATUS), .IRQ_TX(IRQ_TX),
    .IRQ_RX(IRQ_RX));

  can_far_model can_far_model_i (.MCLK(MCLK), .TX_EV(TX_EV), .RX_EV(RX_EV), .WAKE_EVENT(WAKE_EVENT),
    .TX_ERR_COUNT(TX_ERR_COUNT), .RX_ERR_COUNT(RX_ERR_COUNT), .TX_ERR_OVERFLOW(TX_ERR_OVERFLOW),
    .RX_PIN(RX_PIN), .SAMPLE_BIT_IN(SAMPLE_BIT_IN));

  initial begin
    MCLK = 1'b0;
    forever #50 MCLK = ~MCLK;
  end

  task automatic stop_test();
    $display("Mismatches %0d of %0d comparisons", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // Every access is a few cycles, so this only trips on a hang
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (RELEASE_DONE) rel_seen <= rel_seen + 1;
    if (cyc == 5000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Ready is looked at mid-cycle, where it is settled, and used at the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ga, gw;
    ga = 1'b0;
    gw = 1'b0;
    @(posedge MCLK);
    AWADDR  <= a;
    WDATA   <= {24'h000000, d};
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    do begin
      @(negedge MCLK);
      if (!ga) ga = AWREADY;
      if (!gw) gw = WREADY;
      @(posedge MCLK);
      if (ga) AWVALID <= 1'b0;
      if (gw) WVALID <= 1'b0;
    end while (!(ga && gw));
    do @(negedge MCLK); while (!BVALID);
    rs = BRESP;
    @(posedge MCLK);
    BREADY <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic g;
    @(posedge MCLK);
    ARADDR  <= a;
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    do begin
      @(negedge MCLK);
      g = ARREADY;
      @(posedge MCLK);
    end while (!g);
    ARVALID <= 1'b0;
    do @(negedge MCLK); while (!RVALID);
    d  = RDATA;
    rs = RRESP;
    @(posedge MCLK);
    RREADY <= 1'b0;
  endtask : rd

  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(n, d, {24'h000000, e});
  endtask : rc

  task automatic t_reset();
    logic [31:0] d;
    rc("tsr", 8'h08, 8'h00);
    rc("tpr", 8'h0C, 8'h0C);
    rc("rfr", 8'h10, 8'h00);
    rc("ier", 8'h14, 8'h00);
    rc("dgr", 8'h18, 8'h08);
    rc("psr", 8'h1C, 8'h00);
    rc("esr", 8'h20, 8'h00);
    rd(8'h40, d);
    chk("unmapped", 32'(rs), 32'(can_stat_pkg::RESP_SLVERR));
    wr(8'h14, 8'hFF);
    chk("bresp", 32'(rs), 32'(can_stat_pkg::RESP_OKAY));
    rc("ier_rsv", 8'h14, 8'h8F);
  endtask : t_reset

  task automatic t_tx();
    wr(8'h14, 8'h01);
    can_far_model_i.ev({3'b000, 3'b001, 3'b001, 9'h000}, 7'h00, 1'b0);
    rc("ok0", 8'h08, 8'h11);
    chk("irq_tx", 32'(IRQ_TX), 32'h1);
    wr(8'h08, 8'h01);
    rc("clr0", 8'h08, 8'h00);
    chk("irq_tx0", 32'(IRQ_TX), 32'h0);
    can_far_model_i.ev({3'b000, 3'b100, 3'b110, 9'h000}, 7'h00, 1'b0);
    rc("ok2", 8'h08, 8'h46);
    can_far_model_i.ev({3'b100, 3'b000, 3'b000, 9'h000}, 7'h00, 1'b0);
    rc("req2", 8'h08, 8'h06);
    wr(8'h14, 8'h00);
    chk("irq_mask", 32'(IRQ_TX), 32'h0);
    wr(8'h08, 8'h07);
    rc("clr_all", 8'h08, 8'h00);
  endtask : t_tx

  task automatic t_rx();
    wr(8'h14, 8'h02);
    can_far_model_i.ev(18'h00000, 7'h40, 1'b0);
    rc("cnt1", 8'h10, 8'h01);
    chk("irq_rx", 32'(IRQ_RX), 32'h1);
    can_far_model_i.ev(18'h00000, 7'h40, 1'b0);
    can_far_model_i.ev(18'h00000, 7'h40, 1'b0);
    rc("full", 8'h10, 8'h0B);
    can_far_model_i.ev(18'h00000, 7'h20, 1'b0);
    rc("ovr", 8'h10, 8'h1B);
    wr(8'h10, 8'h20);
    rc("rel", 8'h10, 8'h12);
    wr(8'h10, 8'h10);
    rc("ovr_clr", 8'h10, 8'h02);
    wr(8'h10, 8'h20);
    wr(8'h10, 8'h20);
    rc("empty", 8'h10, 8'h00);
    wr(8'h10, 8'h20);
    rc("rel_empty", 8'h10, 8'h00);
    chk("irq_rx0", 32'(IRQ_RX), 32'h0);
    chk("releases", 32'(rel_seen), 32'h3);
  endtask : t_rx

  task automatic t_diag();
    can_far_model_i.lv(8'h60, 8'h7F, 1'b0, 1'b1, 1'b0);
    wr(8'h18, 8'hFF);
    rc("dgr_all", 8'h18, 8'h1B);
    chk("modes", 32'({THIRD_MB_EN, SILENT_MODE, LOOPBACK_MODE}), 32'h7);
    can_far_model_i.lv(8'h60, 8'h7F, 1'b0, 1'b0, 1'b1);
    rc("pins", 8'h18, 8'h17);
    can_far_model_i.ev({9'h000, 3'b011, 6'b011000}, 7'h00, 1'b0);
    rc("free2", 8'h0C, 8'h52);
    can_far_model_i.ev({9'h000, 3'b111, 6'b100100}, 7'h00, 1'b0);
    rc("lowest_prio_mb2", 8'h0C, 8'h82);
    wr(8'h18, 8'h01);
    chk("loop", 32'({THIRD_MB_EN, SILENT_MODE, LOOPBACK_MODE}), 32'h1);
    can_far_model_i.ev({9'h000, 3'b011, 6'b000100}, 7'h00, 1'b0);
    rc("two_mb", 8'h0C, 8'h41);
    can_far_model_i.ev(18'h00000, 7'h00, 1'b0);
  endtask : t_diag

  task automatic t_err();
    can_far_model_i.lv(8'h60, 8'h60, 1'b0, 1'b1, 1'b0);
    rc("below", 8'h20, 8'h00);
    for (int i = 1; i < 7; i++) begin
      can_far_model_i.ev(18'h00000, {4'h1, i[2:0]}, 1'b0);
      rc("err_code", 8'h20, {1'b0, i[2:0], 4'h0});
    end
    can_far_model_i.ev(18'h00000, 7'h10, 1'b0);
    rc("code_ok", 8'h20, 8'h00);
    wr(8'h20, 8'h70);
    rc("code_sw", 8'h20, 8'h70);
    can_far_model_i.lv(8'h61, 8'h00, 1'b0, 1'b1, 1'b0);
    rc("warn", 8'h20, 8'h71);
    can_far_model_i.lv(8'h00, 8'h80, 1'b0, 1'b1, 1'b0);
    rc("passive", 8'h20, 8'h73);
    can_far_model_i.lv(8'hFF, 8'h00, 1'b1, 1'b1, 1'b0);
    rc("busoff", 8'h20, 8'h77);
    can_far_model_i.ev(18'h00000, 7'h00, 1'b1);
    rc("wake", 8'h20, 8'hF7);
    chk("wake_mask", 32'(IRQ_STATUS), 32'h0);
    wr(8'h14, 8'h80);
    chk("wake_irq", 32'(IRQ_STATUS), 32'h1);
    wr(8'h20, 8'h80);
    rc("wake_clr", 8'h20, 8'h07);
  endtask : t_err

  task automatic t_page();
    for (int i = 0; i < 8; i++) begin
      wr(8'h1C, {5'h1F, i[2:0]});
      chk("page", 32'(PAGE_SEL), 32'(i[2:0]));
      rc("psr_rsv", 8'h1C, {5'h00, i[2:0]});
    end
  endtask : t_page

  initial begin
    {RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, AWADDR, ARADDR, WDATA} = '0;
    WSTRB      = 4'hF;
    fail_count = 0;
    cmp_count  = 0;
    cyc        = 0;
    rel_seen   = 0;
    repeat (6) @(posedge MCLK);
    RST_N <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_diag();
    t_err();
    t_page();
    stop_test();
  end
endmodule : can_status_fifo_diag_regs_bench
